/* File: design/cbdm_pkg.sv */
// Notes on behaviour
// - Decode transfer type bits 0-3, ignore bit 4
// - Address-only types get address acknowledge only
// - Writes go to memory or PCI by address
// - Write-with-kill to memory also invalidates cache block
// - Kill block acks; invalidates cache only for memory
// - All read types give identical read
// - Control-out write acked unless another device claims
// - Control-in returns all ones unless claimed
// - Lowest 2G maps to memory unchanged
// - 3G-8M to 3G: interrupt acknowledge, rest unoccupied
// - Top 2M: direct ROM or remote PCI memory
// - Unoccupied addresses read ones, writes ignored
// - Two registers select contiguous or compressed I/O
// - Each 4K page maps to own 32-byte group
// - Rest of page aliases onto first 32 bytes
// - Processor granted the bus whenever idle
// - Precise errors via error ack, imprecise via check
// - Processor data bus is 64 bits wide
// - Contiguous I/O keeps low 30 address bits
// - Contiguous mode selected after reset
// - Absent memory reads ones, sets select error
package cbdm_pkg;
  localparam logic [3:0] TT_WR_FLUSH = 4'h1;
  localparam logic [3:0] TT_WR_KILL = 4'h3;
  localparam logic [3:0] TT_READ = 4'h5;
  localparam logic [3:0] TT_KILL = 4'h6;
  localparam logic [3:0] TT_RD_MOD = 4'h7;
  localparam logic [3:0] TT_WR_ATOM = 4'h9;
  localparam logic [3:0] TT_EXT_OUT = 4'hA;
  localparam logic [3:0] TT_RD_ATOM = 4'hD;
  localparam logic [3:0] TT_EXT_IN = 4'hE;
  localparam logic [3:0] TT_RD_MOD_ATOM = 4'hF;
  localparam logic [31:0] A_CFG0_BASE = 32'h8080_0000;
  localparam logic [31:0] A_IO_BASE = 32'h8100_0000;
  localparam logic [31:0] A_CTRL_BASE = 32'hBF80_0000;
  localparam logic [31:0] A_PMEM_BASE = 32'hC000_0000;
  localparam logic [31:0] A_ROM_BASE = 32'hFFE0_0000;
  localparam logic [31:0] A_INTACK = 32'hBFFF_FFF0;
  localparam logic [31:0] A_IO_MAP = 32'h8000_0850;
  localparam logic [31:0] A_CTRL_INDEX = 32'h8000_0840;
  localparam logic [31:0] A_CTRL_DATA = 32'h8000_0844;
  localparam logic [7:0] IDX_OPT_ONE = 8'hBA;
  localparam logic [7:0] IDX_ERR_ONE = 8'hC1;
  localparam int IOMAP_NC_BIT = 0;
  localparam int OPT_NC_BIT = 0;
  localparam int ERR_MEMSEL_BIT = 5;
  localparam logic [7:0] IO_MAP_RESET = 8'h00;
  localparam logic [7:0] OPT_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_INDEX_RESET = 8'h00;
  localparam logic [7:0] ONES8 = 8'hFF;
  localparam logic [63:0] ONES64 = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [2:0] PCMD_IO = 3'h0;
  localparam logic [2:0] PCMD_CFG0 = 3'h1;
  localparam logic [2:0] PCMD_MEM = 3'h3;
  localparam logic [2:0] PCMD_INTACK = 3'h4;
  typedef enum logic [2:0] {
    TGT_MEM = 3'h0,
    TGT_PIO = 3'h1,
    TGT_CFG0 = 3'h2,
    TGT_CTRL = 3'h3,
    TGT_PMEM = 3'h4,
    TGT_ROM = 3'h5
  } cbdm_target_e;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_MEM = 5'h02,
    ST_PCI = 5'h04,
    ST_RESP = 5'h08,
    ST_ERR = 5'h10
  } cbdm_state_e;
endpackage

/* File: design/cbdm_addr_xlate.sv */
`timescale 1ns/1ns
`default_nettype none
module cbdm_addr_xlate
  import cbdm_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic noncontig,
  input wire logic rom_remote,
  output var cbdm_target_e target,
  output logic [31:0] target_addr
);
  logic in_high;
  logic in_cfg0;
  logic in_io;
  logic in_ctrl;
  logic in_pmem;
  logic rom_direct;
  logic [31:0] strip_addr;
  logic [31:0] nc_addr;
  logic [31:0] rom_addr;

  // Range compares
  assign in_high = addr[31];
  assign in_cfg0 = addr >= A_CFG0_BASE;
  assign in_io = addr >= A_IO_BASE;
  assign in_ctrl = addr >= A_CTRL_BASE;
  assign in_pmem = addr >= A_PMEM_BASE;
  assign rom_direct = (addr >= A_ROM_BASE) & ~rom_remote;

  // Translated forms
  assign strip_addr = {2'b00, addr[29:0]};
  assign nc_addr = {16'h0000, addr[22:12], addr[4:0]};
  assign rom_addr = {11'h000, addr[20:0]};

  assign target = rom_direct ? TGT_ROM :
                  in_pmem ? TGT_PMEM :
                  in_ctrl ? TGT_CTRL :
                  in_io ? TGT_PIO :
                  in_cfg0 ? TGT_CFG0 :
                  in_high ? TGT_PIO : TGT_MEM;

  assign target_addr = ~in_high ? addr :
                       rom_direct ? rom_addr :
                       (~in_cfg0 & noncontig) ? nc_addr :
                       strip_addr;
endmodule
`default_nettype wire

/* File: design/cbdm_top.sv */
`timescale 1ns/1ns
`default_nettype none
module cbdm_top
  import cbdm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ts_n,
  input wire logic extended_transfer_start_n,
  input wire logic [0:4] transfer_type_code,
  input wire logic [31:0] addr,
  input wire logic [63:0] cpu_data_in,
  input wire logic claimed_by_other,
  input wire logic rom_remote,
  input wire logic mem_done,
  input wire logic mem_absent,
  input wire logic [63:0] mem_rdata,
  input wire logic pci_done,
  input wire logic pci_error,
  input wire logic [63:0] pci_rdata,
  output logic bus_grant_n,
  output logic address_acknowledge_n,
  output logic transfer_acknowledge_n,
  output logic transfer_error_acknowledge_n,
  output logic machine_check_n,
  output logic [63:0] cpu_data_out,
  output logic cpu_data_oe,
  output logic mem_req,
  output logic mem_we,
  output logic mem_rom,
  output logic [31:0] mem_addr,
  output logic second_level_cache_invalidate,
  output logic pci_req,
  output logic pci_we,
  output logic [2:0] pci_cmd,
  output logic [31:0] pci_addr,
  output logic memsel_error
);
  cbdm_state_e st;
  cbdm_state_e next_st;
  cbdm_target_e target;
  logic [31:0] xaddr;
  logic [3:0] tt;
  logic [7:0] io_map_select;
  logic [7:0] bridge_options_one;
  logic [7:0] ctrl_index;
  logic [7:0] err_byte;
  logic [7:0] idx_rdata;
  logic [7:0] reg_rdata;
  logic [63:0] quick_data;
  logic [63:0] next_data;
  logic [2:0] next_cmd;
  logic [31:0] nc_expect;
  logic [31:0] strip_expect;
  logic st_idle;
  logic start;
  logic err_go;
  logic is_read;
  logic is_write;
  logic is_kill;
  logic ext_out;
  logic ext_in;
  logic addr_only;
  logic in_mem;
  logic noncontig;
  logic hit_iomap;
  logic hit_idx;
  logic hit_data;
  logic reg_hit;
  logic reg_wr;
  logic int_ack;
  logic ctrl_void;
  logic mem_go;
  logic pci_go;
  logic inval_go;
  logic quick;
  logic quick_ta;
  logic quick_rd;
  logic next_ta;
  logic next_rd;
  logic wr_lat;
  logic mcheck;
  logic memsel_set;
  logic memsel_clr;
  logic go_mem;
  logic go_pci;

  cbdm_addr_xlate u_xlate (
    .addr(addr),
    .noncontig(noncontig),
    .rom_remote(rom_remote),
    .target(target),
    .target_addr(xaddr)
  );

  // Transfer type classes
  assign tt = transfer_type_code[0:3];
  assign is_read = (tt == TT_READ) | (tt == TT_RD_MOD) |
                   (tt == TT_RD_ATOM) | (tt == TT_RD_MOD_ATOM);
  assign is_write = (tt == TT_WR_FLUSH) | (tt == TT_WR_KILL) |
                    (tt == TT_WR_ATOM);
  assign is_kill = tt == TT_KILL;
  assign ext_out = tt == TT_EXT_OUT;
  assign ext_in = tt == TT_EXT_IN;
  assign addr_only = ~(is_read | is_write | is_kill | ext_out | ext_in);

  // Start qualifiers
  assign st_idle = st == ST_IDLE;
  assign err_go = st_idle & ~extended_transfer_start_n;
  assign start = st_idle & ~ts_n & extended_transfer_start_n;

  // Target and register decode
  assign in_mem = ~addr[31];
  assign noncontig = io_map_select[IOMAP_NC_BIT] |
                     bridge_options_one[OPT_NC_BIT];
  assign hit_iomap = addr == A_IO_MAP;
  assign hit_idx = addr == A_CTRL_INDEX;
  assign hit_data = addr == A_CTRL_DATA;
  assign reg_hit = (is_read | is_write) & (hit_iomap | hit_idx | hit_data);
  assign reg_wr = start & is_write;
  assign int_ack = is_read & (addr == A_INTACK);
  assign ctrl_void = (is_read | is_write) & (target == TGT_CTRL) &
                     ~int_ack;
  assign mem_go = (is_read | is_write) & ~reg_hit &
                  ((target == TGT_MEM) | (target == TGT_ROM));
  assign pci_go = (is_read | is_write) & ~reg_hit & ~ctrl_void &
                  (target != TGT_MEM) & (target != TGT_ROM);
  assign inval_go = ((tt == TT_WR_KILL) | is_kill) &
                    (target == TGT_MEM);
  assign quick = addr_only | is_kill | reg_hit | ctrl_void |
                 ((ext_out | ext_in) & ~claimed_by_other);
  assign quick_ta = reg_hit | ctrl_void | ext_out | ext_in;
  assign quick_rd = (is_read & (reg_hit | ctrl_void)) | ext_in;
  assign go_mem = start & mem_go;
  assign go_pci = start & pci_go;

  // Register read path
  always_comb begin
    err_byte = 8'h00;
    err_byte[ERR_MEMSEL_BIT] = memsel_error;
  end
  assign idx_rdata = (ctrl_index == IDX_OPT_ONE) ? bridge_options_one :
                     (ctrl_index == IDX_ERR_ONE) ? err_byte : ONES8;
  assign reg_rdata = hit_iomap ? io_map_select :
                     hit_idx ? ctrl_index : idx_rdata;
  assign quick_data = reg_hit ? {56'h00_0000_0000_0000, reg_rdata}
                              : ONES64;

  // PCI command select
  assign next_cmd = int_ack ? PCMD_INTACK :
                    (target == TGT_CFG0) ? PCMD_CFG0 :
                    (target == TGT_PIO) ? PCMD_IO : PCMD_MEM;

  // Answer selection
  assign next_ta = st_idle ? quick_ta : 1'b1;
  assign next_rd = st_idle ? quick_rd : ~wr_lat;
  assign next_data = st_idle ? quick_data :
                     (st == ST_MEM) ? (mem_absent ? ONES64 : mem_rdata)
                                    : pci_rdata;
  assign mcheck = (st == ST_PCI) & pci_done & pci_error & wr_lat;
  assign memsel_set = (st == ST_MEM) & mem_done & mem_absent;
  assign memsel_clr = start & is_write & hit_data &
                      (ctrl_index == IDX_ERR_ONE) &
                      cpu_data_in[ERR_MEMSEL_BIT];

  // Helpers for checks
  assign nc_expect = {16'h0000, addr[22:12], addr[4:0]};
  assign strip_expect = {2'b00, addr[29:0]};

  always_comb begin
    next_st = st;
    unique case (st)
      ST_IDLE: begin
        if (err_go) begin
          next_st = ST_ERR;
        end else if (go_mem) begin
          next_st = ST_MEM;
        end else if (go_pci) begin
          next_st = ST_PCI;
        end else if (start & quick) begin
          next_st = ST_RESP;
        end
      end
      ST_MEM: if (mem_done) next_st = ST_RESP;
      ST_PCI: begin
        if (pci_done) begin
          next_st = (pci_error & ~wr_lat) ? ST_ERR : ST_RESP;
        end
      end
      ST_RESP, ST_ERR: next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_map_select <= IO_MAP_RESET;
      bridge_options_one <= OPT_ONE_RESET;
      ctrl_index <= CTRL_INDEX_RESET;
    end else if (reg_wr) begin
      if (hit_iomap) io_map_select <= cpu_data_in[7:0];
      if (hit_idx) ctrl_index <= cpu_data_in[7:0];
      if (hit_data & (ctrl_index == IDX_OPT_ONE)) begin
        bridge_options_one <= cpu_data_in[7:0];
      end
    end
  end

  // Sticky select error, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memsel_error <= 1'b0;
    end else begin
      memsel_error <= memsel_set | (memsel_error & ~memsel_clr);
    end
  end

  // Processor bus answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_grant_n <= 1'b0;
      address_acknowledge_n <= 1'b1;
      transfer_acknowledge_n <= 1'b1;
      transfer_error_acknowledge_n <= 1'b1;
      machine_check_n <= 1'b1;
      cpu_data_oe <= 1'b0;
      cpu_data_out <= ONES64;
    end else begin
      bus_grant_n <= next_st != ST_IDLE;
      address_acknowledge_n <= ~((next_st == ST_RESP) |
                                 (next_st == ST_ERR));
      transfer_acknowledge_n <= ~((next_st == ST_RESP) & next_ta);
      transfer_error_acknowledge_n <= next_st != ST_ERR;
      machine_check_n <= ~mcheck;
      cpu_data_oe <= (next_st == ST_RESP) & next_ta & next_rd;
      if (next_st == ST_RESP) cpu_data_out <= next_data;
    end
  end

  // Memory and PCI requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      pci_req <= 1'b0;
      second_level_cache_invalidate <= 1'b0;
    end else begin
      mem_req <= go_mem;
      pci_req <= go_pci;
      second_level_cache_invalidate <= start & inval_go;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we <= 1'b0;
      mem_rom <= 1'b0;
      mem_addr <= 32'h0000_0000;
      pci_we <= 1'b0;
      pci_cmd <= PCMD_IO;
      pci_addr <= 32'h0000_0000;
      wr_lat <= 1'b0;
    end else if (start) begin
      mem_we <= is_write;
      mem_rom <= target == TGT_ROM;
      mem_addr <= xaddr;
      pci_we <= is_write;
      pci_cmd <= next_cmd;
      pci_addr <= xaddr;
      wr_lat <= is_write;
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ack_only;
    !address_acknowledge_n && transfer_acknowledge_n &&
      !mem_req && !pci_req;
  endsequence
  sequence s_ack_ta;
    !address_acknowledge_n && !transfer_acknowledge_n && !pci_req;
  endsequence
  sequence s_quiet;
    address_acknowledge_n && transfer_acknowledge_n;
  endsequence

  addr_only_ack_a: assert property (
    start && addr_only |=> s_ack_only ##1 s_quiet)
    else $error("address-only transfer answered wrongly");
  write_mem_a: assert property (
    start && is_write && in_mem |=>
      mem_req && mem_we && !pci_req && mem_addr == $past(addr))
    else $error("memory write not issued");
  write_pci_a: assert property (
    start && is_write && (target == TGT_PMEM) |=>
      pci_req && pci_we && pci_cmd == PCMD_MEM && !mem_req)
    else $error("PCI write not issued");
  kill_write_a: assert property (
    start && (tt == TT_WR_KILL) && in_mem |=>
      second_level_cache_invalidate && mem_req)
    else $error("write with kill missed invalidate");
  kill_block_a: assert property (
    start && is_kill |=> s_ack_only and
      (second_level_cache_invalidate == $past(in_mem)))
    else $error("kill block handled wrongly");
  read_mem_a: assert property (
    start && is_read && in_mem |=>
      mem_req && !mem_we && mem_addr == $past(addr))
    else $error("memory read not issued");
  ext_out_a: assert property (
    start && ext_out && !claimed_by_other |=> s_ack_ta ##1 s_quiet)
    else $error("control-out not acknowledged");
  ext_in_a: assert property (
    start && ext_in && !claimed_by_other |=>
      s_ack_ta and (cpu_data_oe && cpu_data_out == ONES64))
    else $error("control-in did not return ones");
  claimed_a: assert property (
    start && (ext_out || ext_in) && claimed_by_other |=>
      address_acknowledge_n [*2])
    else $error("claimed transfer was acknowledged");
  contig_io_a: assert property (
    go_pci && !noncontig && (target == TGT_PIO) |=>
      pci_addr == $past(strip_expect) && pci_cmd == PCMD_IO)
    else $error("contiguous I/O address wrong");
  noncontig_io_a: assert property (
    go_pci && noncontig && addr < A_CFG0_BASE |=>
      pci_addr == $past(nc_expect))
    else $error("compressed I/O address wrong");
  int_ack_a: assert property (
    start && int_ack |=> pci_req && pci_cmd == PCMD_INTACK)
    else $error("interrupt acknowledge not issued");
  void_read_a: assert property (
    start && is_read && ctrl_void |=>
      s_ack_ta and (cpu_data_out == ONES64))
    else $error("unoccupied read not all ones");
  absent_mem_a: assert property (
    memsel_set && !wr_lat |=>
      s_ack_ta and (memsel_error && cpu_data_out == ONES64))
    else $error("absent memory read handled wrongly");
  xfer_error_a: assert property (
    err_go |=> !transfer_error_acknowledge_n &&
      !address_acknowledge_n ##1 transfer_error_acknowledge_n)
    else $error("extended transfer not refused");
  bus_park_a: assert property (
    (st == ST_IDLE) |-> !bus_grant_n)
    else $error("idle bus not parked on processor");
endmodule
`default_nettype wire

/* File: test/cbdm_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cbdm_far_model #(
  parameter logic [31:0] MEM_TOP = 32'h1000_0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic pci_fail,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic pci_req,
  input wire logic [31:0] pci_addr,
  output logic mem_done,
  output logic mem_absent,
  output logic [63:0] mem_rdata,
  output logic pci_done,
  output logic pci_error,
  output logic [63:0] pci_rdata
);
  logic [3:0] mcnt;
  logic [3:0] pcnt;
  // Data is only meaningful with done; otherwise it toggles every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mcnt <= 4'h0;
      pcnt <= 4'h0;
      mem_done <= 1'b0;
      mem_absent <= 1'b0;
      mem_rdata <= 64'h0;
      pci_done <= 1'b0;
      pci_error <= 1'b0;
      pci_rdata <= 64'h0;
    end else begin
      mem_done <= (mcnt == 4'h1);
      mem_absent <= (mcnt == 4'h1) && (mem_addr >= MEM_TOP);
      mem_rdata <= (mcnt == 4'h1) ? {~mem_addr, mem_addr} : ~mem_rdata;
      pci_done <= (pcnt == 4'h1);
      pci_error <= (pcnt == 4'h1) && pci_fail;
      pci_rdata <= (pcnt == 4'h1) ? {pci_addr, ~pci_addr} : ~pci_rdata;
      if (mem_req) begin
        mcnt <= slow ? 4'h5 : 4'h1;
      end else if (mcnt != 4'h0) begin
        mcnt <= mcnt - 4'h1;
      end
      if (pci_req) begin
        pcnt <= slow ? 4'h6 : 4'h1;
      end else if (pcnt != 4'h0) begin
        pcnt <= pcnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cbdm_pkg::*;
  logic clk = 0, rst_n = 0, ts_n = 1, extended_transfer_start_n = 1;
  logic [0:4] transfer_type_code = 5'h00;
  logic [31:0] addr = 32'h0;
  logic [63:0] cpu_data_in = 64'h0;
  logic claimed_by_other = 0, rom_remote = 0, slow = 0, pci_fail = 0;
  logic mem_done, mem_absent, pci_done, pci_error;
  logic [63:0] mem_rdata, pci_rdata, cpu_data_out;
  logic bus_grant_n, address_acknowledge_n, transfer_acknowledge_n;
  logic transfer_error_acknowledge_n, machine_check_n, cpu_data_oe;
  logic mem_req, mem_we, mem_rom, second_level_cache_invalidate;
  logic pci_req, pci_we, memsel_error;
  logic [2:0] pci_cmd;
  logic [31:0] mem_addr, pci_addr;
  logic r_ack, r_ta, r_tea, r_mcp, r_oe, r_mreq, r_inv, r_preq;
  int fails = 0, comparisons = 0, cyc = 0;
  cbdm_top i_cbdm_top (.*);
  cbdm_far_model i_cbdm_far_model (.clk(clk), .rst_n(rst_n),
    .slow(slow), .pci_fail(pci_fail), .mem_req(mem_req),
    .mem_addr(mem_addr), .pci_req(pci_req), .pci_addr(pci_addr),
    .mem_done(mem_done), .mem_absent(mem_absent), .mem_rdata(mem_rdata),
    .pci_done(pci_done), .pci_error(pci_error), .pci_rdata(pci_rdata));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %b", $time, msg, got);
    end
  endtask
  // One processor transfer; x selects the unsupported extended start
  task automatic xfer(input logic [3:0] tt, input logic [31:0] a,
                      input logic [63:0] d, input logic x);
    int n;
    n = 0;
    {r_ack, r_ta, r_tea, r_mcp, r_oe, r_mreq, r_inv, r_preq} = 8'h00;
    ts_n = x;
    extended_transfer_start_n = ~x;
    transfer_type_code = {tt, ~tt[0]};
    addr = a;
    cpu_data_in = d;
    while (!r_ack && n < 40) begin
      @(negedge clk);
      ts_n = 1'b1;
      extended_transfer_start_n = 1'b1;
      n++;
      r_ack = !address_acknowledge_n;
      r_ta |= !transfer_acknowledge_n;
      r_tea |= !transfer_error_acknowledge_n;
      r_mcp |= !machine_check_n;
      r_oe |= cpu_data_oe;
      r_mreq |= mem_req;
      r_inv |= second_level_cache_invalidate;
      r_preq |= pci_req;
    end
    // Let the answer cycle pass; a request there is ignored
    @(negedge clk);
  endtask
  task automatic pci_case(input logic [3:0] tt, input logic [31:0] a,
                          input logic [2:0] cmd, input logic [31:0] pa);
    xfer(tt, a, 64'h0, 1'b0);
    chk1(r_preq & ~r_mreq, 1'b1, "pci request");
    chk({61'h0, pci_cmd}, {61'h0, cmd}, "pci command");
    chk({32'h0, pci_addr}, {32'h0, pa}, "pci address");
  endtask
  task automatic t_basic();
    logic [3:0] q[$];
    chk1(bus_grant_n, 1'b0, "grant idle");
    chk(cpu_data_out, ONES64, "data reset");
    q = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hB, 4'hC};
    foreach (q[i]) begin
      xfer(q[i], 32'h0000_1000, 64'h0, 1'b0);
      chk1(r_ack & ~r_ta & ~r_mreq & ~r_preq, 1'b1, "addr only");
    end
    xfer(TT_KILL, 32'h0000_2000, 64'h0, 1'b0);
    chk1(r_inv & ~r_mreq & ~r_preq, 1'b1, "kill mem");
    xfer(TT_KILL, 32'hC000_2000, 64'h0, 1'b0);
    chk1(r_ack & ~r_inv & ~r_preq, 1'b1, "kill pci");
    chk1(bus_grant_n, 1'b0, "grant after");
    $display("test basic done");
  endtask
  task automatic t_mem();
    logic [3:0] q[$];
    q = '{TT_READ, TT_RD_MOD, TT_RD_ATOM, TT_RD_MOD_ATOM};
    foreach (q[i]) begin
      slow = i[0];
      xfer(q[i], 32'h0012_3458, 64'h0, 1'b0);
      chk1(r_mreq & ~mem_we & r_ta & r_oe, 1'b1, "mem read");
      chk({32'h0, mem_addr}, 64'h0000_0000_0012_3458, "mem addr");
      chk(cpu_data_out, 64'hFFED_CBA7_0012_3458, "read data");
    end
    q = '{TT_WR_FLUSH, TT_WR_KILL, TT_WR_ATOM};
    foreach (q[i]) begin
      xfer(q[i], 32'h7FFF_FFF8, 64'h5, 1'b0);
      chk1(r_mreq & mem_we & ~r_preq, 1'b1, "mem write");
      chk1(r_inv, q[i] == TT_WR_KILL, "write kill");
    end
    xfer(TT_WR_FLUSH, 32'h8100_0010, 64'h5, 1'b0);
    chk1(r_preq & pci_we & ~r_mreq, 1'b1, "pci write");
    slow = 0;
    $display("test mem done");
  endtask
  task automatic t_ext();
    xfer(TT_EXT_IN, 32'h0, 64'h0, 1'b0);
    chk1(r_ta & r_oe & ~r_preq, 1'b1, "ctl in");
    chk(cpu_data_out, ONES64, "ctl in ones");
    xfer(TT_EXT_OUT, 32'h0, 64'h0, 1'b0);
    chk1(r_ack & r_ta & ~r_preq & ~r_mreq, 1'b1, "ctl out");
    claimed_by_other = 1;
    xfer(TT_EXT_OUT, 32'h0, 64'h0, 1'b0);
    chk1(r_ack | r_ta, 1'b0, "claimed out");
    xfer(TT_EXT_IN, 32'h0, 64'h0, 1'b0);
    chk1(r_ack | r_ta, 1'b0, "claimed in");
    claimed_by_other = 0;
    $display("test ext done");
  endtask
  task automatic t_map();
    pci_case(TT_READ, 32'h8080_0800, PCMD_CFG0, 32'h0080_0800);
    pci_case(TT_READ, 32'hBF7F_FFFC, PCMD_IO, 32'h3F7F_FFFC);
    pci_case(TT_READ, 32'hC000_0100, PCMD_MEM, 32'h0000_0100);
    pci_case(TT_READ, A_INTACK, PCMD_INTACK, A_INTACK & 32'h3FFF_FFFF);
    rom_remote = 1;
    pci_case(TT_READ, 32'hFFE0_0040, PCMD_MEM, 32'h3FE0_0040);
    rom_remote = 0;
    xfer(TT_READ, 32'hFFE0_0040, 64'h0, 1'b0);
    chk1(r_mreq & mem_rom & ~r_preq, 1'b1, "rom direct");
    chk({32'h0, mem_addr}, 64'h0000_0000_0000_0040, "rom addr");
    $display("test map done");
  endtask
  task automatic t_io();
    xfer(TT_READ, A_IO_MAP, 64'h0, 1'b0);
    chk(cpu_data_out, 64'h0, "map reset");
    pci_case(TT_READ, 32'h8000_3FE5, PCMD_IO, 32'h0000_3FE5);
    xfer(TT_WR_FLUSH, A_IO_MAP, 64'h1, 1'b0);
    xfer(TT_READ, A_IO_MAP, 64'h0, 1'b0);
    chk(cpu_data_out, 64'h1, "map readback");
    pci_case(TT_READ, 32'h8000_3FE5, PCMD_IO, 32'h0000_0065);
    pci_case(TT_READ, 32'h807F_F01F, PCMD_IO, 32'h0000_FFFF);
    xfer(TT_WR_FLUSH, A_IO_MAP, 64'h0, 1'b0);
    xfer(TT_WR_FLUSH, A_CTRL_INDEX, {56'h0, IDX_OPT_ONE}, 1'b0);
    xfer(TT_WR_FLUSH, A_CTRL_DATA, 64'h1, 1'b0);
    pci_case(TT_READ, 32'h8000_2003, PCMD_IO, 32'h0000_0043);
    xfer(TT_WR_FLUSH, A_CTRL_DATA, 64'h0, 1'b0);
    $display("test io done");
  endtask
  task automatic t_err();
    xfer(TT_READ, 32'h2000_0000, 64'h0, 1'b0);
    chk(cpu_data_out, ONES64, "absent read");
    chk1(r_ta & memsel_error, 1'b1, "select error");
    xfer(TT_WR_FLUSH, A_CTRL_INDEX, {56'h0, IDX_ERR_ONE}, 1'b0);
    xfer(TT_READ, A_CTRL_DATA, 64'h0, 1'b0);
    chk(cpu_data_out, 64'h20, "error status");
    xfer(TT_WR_FLUSH, A_CTRL_DATA, 64'h20, 1'b0);
    chk1(memsel_error, 1'b0, "error clear");
    xfer(TT_WR_FLUSH, A_CTRL_INDEX, 64'h55, 1'b0);
    xfer(TT_READ, A_CTRL_DATA, 64'h0, 1'b0);
    chk(cpu_data_out, 64'hFF, "unmapped index");
    xfer(TT_READ, 32'hBF80_0100, 64'h0, 1'b0);
    chk(cpu_data_out, ONES64, "empty window");
    xfer(TT_READ, 32'h0, 64'h0, 1'b1);
    chk1(r_tea & ~r_mreq & ~r_preq, 1'b1, "extended start");
    pci_fail = 1;
    xfer(TT_READ, 32'hC000_0000, 64'h0, 1'b0);
    chk1(r_tea & ~r_ta, 1'b1, "pci read err");
    xfer(TT_WR_FLUSH, 32'hC000_0000, 64'h0, 1'b0);
    chk1(r_mcp & r_ta, 1'b1, "pci write err");
    pci_fail = 0;
    $display("test err done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    t_basic();
    t_mem();
    t_ext();
    t_map();
    t_io();
    t_err();
    wrap_up();
  end
endmodule
`default_nettype wire
